// [logic/sbm_bus_if.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sbm_consts.svh"

// ----------------------------------------------------------------
// backplane wires; each two-way line is in / out / enable per end
// ----------------------------------------------------------------
interface sbm_bus_if;
    logic [15:0] busAddrInv;
    logic        busAddrOe;
    logic [7:0]  busDataInvM;
    logic        busDataOeM;
    logic [7:0]  busDataInvS;
    logic        busDataOeS;
    logic [7:0]  busDataInv;
    logic        bankSelectNM;
    logic        bankSelectOeM;
    logic        bankSelectNS;
    logic        bankSelectOeS;
    logic        bankSelectN;
    logic        phi1Clk;
    logic        opcodeFetchSync;
    logic        syncOe;
    logic        setOverflowIn;
    logic        readyHoldIn;
    logic        busFloatN;

    // resolved wire levels; undriven lines pulled high
    assign busDataInv  = busDataOeM ? busDataInvM : (busDataOeS ? busDataInvS : 8'hff);
    assign bankSelectN = bankSelectOeM ? bankSelectNM : (bankSelectOeS ? bankSelectNS : 1'b1);

    modport master (
        output busAddrInv, busAddrOe, busDataInvM, busDataOeM, bankSelectNM, bankSelectOeM,
        output phi1Clk, opcodeFetchSync, syncOe,
        input  busDataInv, bankSelectN, setOverflowIn, readyHoldIn, busFloatN
    );
    modport slave (
        output busDataInvS, busDataOeS, bankSelectNS, bankSelectOeS,
        output setOverflowIn, readyHoldIn, busFloatN,
        input  busAddrInv, busAddrOe, busDataInv, bankSelectN, phi1Clk, opcodeFetchSync, syncOe
    );
endinterface

`default_nettype wire

// [logic/sbm_consts.svh]
`ifndef SBM_CONSTS_SVH
`define SBM_CONSTS_SVH

// ----------------------------------------------------------------
// widths and levels
// ----------------------------------------------------------------
`define SBM_ADDR_W        16
`define SBM_DATA_W        8
`define SBM_BANK0_LEVEL   1'b1
`define SBM_BANK1_LEVEL   1'b0
// phase-1 half period in ref_clk cycles
`define SBM_PHI1_HALF     4'h4

`endif

// [logic/sbm_master.sv]
// Overview of operation
// - drive inverted 16-bit address onto bus
// - float address drivers while bus float low
// - data moves inverted over eight bidirectional lines
// - float data transceivers while bus float active
// - onboard bank: drive programmed or high level
// - external bank: take bank select from bus
// - high selects bank 0, low bank 1
// - phase-1 clock driven always, never floated
// - sync high from phi1 high during fetch
// - float sync while bus float active
// - set-overflow falling edge sets overflow flag
// - ready low halts at next read cycle
// - dma master takes bus via float low
`timescale 1ns/10ps
`default_nettype none
`include "sbm_consts.svh"

module sbm_master
    import sbm_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // cpu side request
    input  wire logic        reqValid,
    input  wire logic        reqWrite,
    input  wire logic        reqFetch,
    input  wire logic [15:0] reqAddr,
    input  wire logic [7:0]  reqWdata,
    // bank control
    input  wire logic        bankExternal,
    input  wire logic        bankUseProg,
    input  wire logic        bankProgLevel,
    // cpu side answers and overflow clear
    output logic             reqReady,
    output logic             rspValid,
    output logic [7:0]       rspRdata,
    output logic             bankUpper,
    output logic             overflowFlag,
    input  wire logic        overflowClr,
    // backplane
    sbm_bus_if.master        bus
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        sbm_phase_t  phase;
        logic [3:0]  cnt;
        logic        phi1;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        active;
        logic        sync;
        logic        reqReady;
        logic        rspValid;
        logic [7:0]  rdata;
        logic [2:0]  floatSy;
        logic [2:0]  soSy;
        logic [2:0]  rdySy;
        logic [2:0]  bankSy;
        logic [7:0]  dataSy0;
        logic [7:0]  dataSy1;
        logic [7:0]  dataSy2;
        logic [7:0]  dataIn;
        logic        floatN;
        logic        so;
        logic        rdy;
        logic        bankIn;
        logic        ovf;
        logic        bankUpper;
        logic        addrOe;
        logic        dataOe;
        logic        bankOe;
        logic        bankOut;
        logic        syncOe;
    } sbm_master_t;

    sbm_master_t state_ff;
    sbm_master_t nxt_state;

    // debounce helper: new level once last two stages agree
    function automatic logic sbm_filt(input logic [2:0] sy, input logic cur);
        sbm_filt = (sy[1] == sy[2]) ? sy[2] : cur;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        // three-stage pin synchronisers
        nxt_state.floatSy = {state_ff.floatSy[1:0], bus.busFloatN};
        nxt_state.soSy    = {state_ff.soSy[1:0], bus.setOverflowIn};
        nxt_state.rdySy   = {state_ff.rdySy[1:0], bus.readyHoldIn};
        nxt_state.bankSy  = {state_ff.bankSy[1:0], bus.bankSelectN};
        nxt_state.floatN  = sbm_filt(state_ff.floatSy, state_ff.floatN);
        nxt_state.so      = sbm_filt(state_ff.soSy, state_ff.so);
        nxt_state.rdy     = sbm_filt(state_ff.rdySy, state_ff.rdy);
        nxt_state.bankIn  = sbm_filt(state_ff.bankSy, state_ff.bankIn);
        // data lines take three stages too; a word counts once stages two and
        // three agree, so skew between bits never reaches the read register
        nxt_state.dataSy0 = bus.busDataInv;
        nxt_state.dataSy1 = state_ff.dataSy0;
        nxt_state.dataSy2 = state_ff.dataSy1;
        if (state_ff.dataSy1 == state_ff.dataSy2)
            nxt_state.dataIn = state_ff.dataSy2;
        nxt_state.reqReady = 1'b0;
        nxt_state.rspValid = 1'b0;

        // falling edge sets overflow; set beats clear
        if (state_ff.so && !nxt_state.so)
            nxt_state.ovf = 1'b1;
        else if (overflowClr)
            nxt_state.ovf = 1'b0;

        // phase-1 clock free-running, unaffected by float
        if (state_ff.cnt == `SBM_PHI1_HALF - 4'h1) begin
            nxt_state.cnt  = 4'h0;
            nxt_state.phi1 = !state_ff.phi1;
        end else begin
            nxt_state.cnt = state_ff.cnt + 4'h1;
        end

        // bank source; high level means bank 0
        nxt_state.bankOut = bankUseProg ? bankProgLevel : `SBM_BANK0_LEVEL;
        if (bankExternal)
            nxt_state.bankUpper = (state_ff.bankIn == `SBM_BANK1_LEVEL);
        else
            nxt_state.bankUpper = (state_ff.bankOut == `SBM_BANK1_LEVEL);

        // cycle sequencing on phi1 edges
        unique case (state_ff.phase)
            SBM_IDLE: begin
                if (reqValid && state_ff.floatN && !state_ff.phi1 && nxt_state.phi1) begin
                    nxt_state.phase    = SBM_PHI1;
                    nxt_state.wr       = reqWrite;
                    nxt_state.addr     = ~reqAddr;
                    nxt_state.wdata    = ~reqWdata;
                    nxt_state.active   = 1'b1;
                    nxt_state.sync     = reqFetch;
                    nxt_state.reqReady = 1'b1;
                end
            end
            SBM_PHI1: begin
                if (state_ff.phi1 && !nxt_state.phi1)
                    nxt_state.phase = SBM_PHI2;
            end
            SBM_PHI2: begin
                // read cycles stretch while ready is low
                if (state_ff.phi1 == 1'b0 && nxt_state.phi1 &&
                    (state_ff.wr || state_ff.rdy)) begin
                    nxt_state.phase  = SBM_IDLE;
                    nxt_state.active = 1'b0;
                    nxt_state.sync   = 1'b0;
                    if (!state_ff.wr) begin
                        nxt_state.rspValid = 1'b1;
                        nxt_state.rdata    = ~state_ff.dataIn;
                    end
                end
            end
            // the spare phase code is never entered; fall back to idle
            default: begin
                nxt_state.phase = SBM_IDLE;
            end
        endcase

        // drivers released while dma owns the bus
        nxt_state.addrOe = state_ff.floatN;
        nxt_state.dataOe = state_ff.floatN && state_ff.active && state_ff.wr;
        nxt_state.syncOe = state_ff.floatN;
        nxt_state.bankOe = state_ff.floatN && !bankExternal;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            // undriven lines read high, so the data stages start high as well
            state_ff <= '{phase: SBM_IDLE, floatSy: 3'h7, soSy: 3'h7, rdySy: 3'h7,
                          bankSy: 3'h7, floatN: 1'b1, so: 1'b1, rdy: 1'b1,
                          bankIn: 1'b1, bankOut: 1'b1, addr: 16'hffff, wdata: 8'hff,
                          dataSy0: 8'hff, dataSy1: 8'hff, dataSy2: 8'hff, dataIn: 8'hff,
                          default: '0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    assign bus.busAddrInv      = state_ff.addr;
    assign bus.busAddrOe       = state_ff.addrOe;
    assign bus.busDataInvM     = state_ff.wdata;
    assign bus.busDataOeM      = state_ff.dataOe;
    assign bus.bankSelectNM    = state_ff.bankOut;
    assign bus.bankSelectOeM   = state_ff.bankOe;
    assign bus.phi1Clk         = state_ff.phi1;
    assign bus.opcodeFetchSync = state_ff.sync;
    assign bus.syncOe          = state_ff.syncOe;
    assign reqReady            = state_ff.reqReady;
    assign rspValid            = state_ff.rspValid;
    assign rspRdata            = state_ff.rdata;
    assign bankUpper           = state_ff.bankUpper;
    assign overflowFlag        = state_ff.ovf;
endmodule

`default_nettype wire

// [logic/sbm_pkg.sv]
`default_nettype none

package sbm_pkg;
    // cpu bus cycle phase as seen by the master end
    typedef enum logic [1:0] {
        SBM_IDLE,
        SBM_PHI1,
        SBM_PHI2
    } sbm_phase_t;

    typedef enum logic {
        SBM_BANK_ONBOARD,
        SBM_BANK_EXTERNAL
    } sbm_banksrc_t;
endpackage

`default_nettype wire

// [logic/sbm_slave.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sbm_consts.svh"

module sbm_slave
    import sbm_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // user control of shared lines
    input  wire logic        floatReq,
    input  wire logic        holdReq,
    input  wire logic        overflowPulse,
    input  wire logic        bankDrive,
    input  wire logic        bankLevel,
    input  wire logic        dataDrive,
    input  wire logic [7:0]  dataOut,
    // observed bus
    output logic [15:0]      seenAddr,
    output logic [7:0]       seenData,
    output logic             seenBank0,
    // backplane
    sbm_bus_if.slave         bus
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        floatN;
        logic        rdy;
        logic        so;
        logic        bankOe;
        logic        bankN;
        logic        dataOe;
        logic [7:0]  dataInv;
        logic [15:0] addr;
        logic [7:0]  data;
        logic        bank0;
    } sbm_slave_t;

    sbm_slave_t state_ff;
    sbm_slave_t nxt_state;

    // ------------------------------------------------------------
    // next state; bus values are registered, not synchronised
    // ------------------------------------------------------------
    always_comb begin
        nxt_state         = state_ff;
        nxt_state.floatN  = !floatReq;
        nxt_state.rdy     = !holdReq;
        nxt_state.so      = !overflowPulse;
        nxt_state.bankOe  = bankDrive;
        nxt_state.bankN   = bankLevel;
        // user keeps data off the lines during master writes
        nxt_state.dataOe  = dataDrive;
        nxt_state.dataInv = ~dataOut;
        nxt_state.addr    = ~bus.busAddrInv;
        nxt_state.data    = ~bus.busDataInv;
        nxt_state.bank0   = (bus.bankSelectN == `SBM_BANK0_LEVEL);
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn)
            state_ff <= '{floatN: 1'b1, rdy: 1'b1, so: 1'b1, bankN: 1'b1, default: '0};
        else
            state_ff <= nxt_state;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.busFloatN     = state_ff.floatN;
    assign bus.readyHoldIn   = state_ff.rdy;
    assign bus.setOverflowIn = state_ff.so;
    assign bus.bankSelectOeS = state_ff.bankOe;
    assign bus.bankSelectNS  = state_ff.bankN;
    assign bus.busDataOeS    = state_ff.dataOe;
    assign bus.busDataInvS   = state_ff.dataInv;
    assign seenAddr          = state_ff.addr;
    assign seenData          = state_ff.data;
    assign seenBank0         = state_ff.bank0;
endmodule

`default_nettype wire

// [verification/sbm_bus_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module sbm_bus_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // watched backplane lines
    input wire logic busAddrOe,
    input wire logic busDataOeM,
    input wire logic busDataOeS,
    input wire logic bankSelectOeM,
    input wire logic bankSelectOeS,
    input wire logic phi1Clk,
    input wire logic opcodeFetchSync,
    input wire logic syncOe,
    input wire logic busFloatN
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // float held longer than the input filter
    // ----------------------------------------
    sequence s_float_held;
        (!busFloatN)[*6];
    endsequence
    sequence s_fetch_rest;
        opcodeFetchSync[*6];
    endsequence
    a_addr_float: assert property (s_float_held |-> !busAddrOe)
        else $error("address driven during float");
    a_data_float: assert property (s_float_held |-> !busDataOeM)
        else $error("data driven during float");
    a_sync_float: assert property (s_float_held |-> !syncOe)
        else $error("sync driven during float");
    a_bank_float: assert property (s_float_held |-> !bankSelectOeM)
        else $error("bank line driven during float");
    // both ends on one line would short the drivers
    a_bank_no_fight: assert property (bankSelectOeS |-> !bankSelectOeM)
        else $error("bank line contention");
    a_data_no_fight: assert property (!(busDataOeM && busDataOeS))
        else $error("data line contention");
    a_phi1_runs: assert property (1'b1 |-> ##[1:5] $changed(phi1Clk))
        else $error("phase one clock stuck");
    a_phi1_half: assert property ($changed(phi1Clk) |=> $stable(phi1Clk)[*3])
        else $error("phase one half period short");
    a_sync_whole: assert property ($rose(opcodeFetchSync) |-> phi1Clk ##1 s_fetch_rest)
        else $error("sync not held for fetch");
endmodule
`default_nettype wire

// [verification/test_sbc_backplane_bus_master.sv]
`timescale 1ns/10ps
`default_nettype none
module test_sbc_backplane_bus_master;
    import sbm_pkg::*;
    logic ref_clk, resetn, reqValid, reqWrite, reqFetch, reqReady, rspValid;
    logic bankExternal, bankUseProg, bankProgLevel, bankUpper, overflowFlag, overflowClr;
    logic floatReq, holdReq, overflowPulse, bankDrive, bankLevel, dataDrive, seenBank0;
    logic [15:0] reqAddr, seenAddr;
    logic [7:0]  reqWdata, rspRdata, dataOut, seenData, rd;
    int          err_total, n_checks, cnt;
    sbm_bus_if sbm_bus_if_inst ();
    sbm_master sbm_master_inst (.ref_clk(ref_clk), .resetn(resetn), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqFetch(reqFetch), .reqAddr(reqAddr), .reqWdata(reqWdata),
        .bankExternal(bankExternal), .bankUseProg(bankUseProg), .bankProgLevel(bankProgLevel),
        .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata), .bankUpper(bankUpper),
        .overflowFlag(overflowFlag), .overflowClr(overflowClr), .bus(sbm_bus_if_inst));
    sbm_slave sbm_slave_inst (.ref_clk(ref_clk), .resetn(resetn), .floatReq(floatReq),
        .holdReq(holdReq), .overflowPulse(overflowPulse), .bankDrive(bankDrive),
        .bankLevel(bankLevel), .dataDrive(dataDrive), .dataOut(dataOut), .seenAddr(seenAddr),
        .seenData(seenData), .seenBank0(seenBank0), .bus(sbm_bus_if_inst));
    sbm_bus_asserts sbm_bus_asserts_inst (.ref_clk(ref_clk), .resetn(resetn),
        .busAddrOe(sbm_bus_if_inst.busAddrOe), .busDataOeM(sbm_bus_if_inst.busDataOeM),
        .busDataOeS(sbm_bus_if_inst.busDataOeS), .bankSelectOeM(sbm_bus_if_inst.bankSelectOeM),
        .bankSelectOeS(sbm_bus_if_inst.bankSelectOeS), .phi1Clk(sbm_bus_if_inst.phi1Clk),
        .opcodeFetchSync(sbm_bus_if_inst.opcodeFetchSync), .syncOe(sbm_bus_if_inst.syncOe),
        .busFloatN(sbm_bus_if_inst.busFloatN));
    // ----------------------------------------
    // clock, compare and close
    // ----------------------------------------
    always #2 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // one cpu cycle; cnt returns cycles from take to answer
    task automatic bus_op(input logic wr, input logic fe, input logic [15:0] a, input logic [7:0] wd);
        reqValid = 1'b1;
        reqWrite = wr;
        reqFetch = fe;
        reqAddr  = a;
        reqWdata = wd;
        for (cnt = 0; cnt < 40 && reqReady !== 1'b1; cnt++) cyc(1);
        chk("taken", reqReady, 1'b1);
        chk("addrWire", sbm_bus_if_inst.busAddrInv, ~a);
        if (fe) chk("sync", sbm_bus_if_inst.opcodeFetchSync, 1'b1);
        reqValid = 1'b0;
        cyc(5);
        if (wr) chk("dataWire", sbm_bus_if_inst.busDataInv, {8'h00, ~wd});
        if (wr) chk("seenData", seenData, wd);
        // a write gives no read answer; it ends when the data drivers let go
        for (cnt = 5; cnt < 90 && rspValid !== 1'b1 && (!wr || sbm_bus_if_inst.busDataOeM === 1'b1); cnt++) cyc(1);
        chk("answer", rspValid, !wr);
        chk("seenAddr", seenAddr, a);
        rd = rspRdata;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_rw;
        bus_op(1'b1, 1'b0, 16'h8001, 8'ha5);
        dataDrive = 1'b1;
        bus_op(1'b0, 1'b1, 16'hfffe, 8'h00);
        chk("readData", rd, 8'h3c);
        dataDrive = 1'b0;
    endtask
    task automatic t_hold;
        holdReq = 1'b1;
        fork
            begin
                cyc(40);
                holdReq = 1'b0;
            end
        join_none
        bus_op(1'b0, 1'b0, 16'h0100, 8'h00);
        chk("stretched", cnt > 35, 1'b1);
    endtask
    task automatic t_float;
        floatReq = 1'b1;
        cyc(10);
        chk("addrOe", sbm_bus_if_inst.busAddrOe, 1'b0);
        chk("dataOe", sbm_bus_if_inst.busDataOeM, 1'b0);
        chk("syncOe", sbm_bus_if_inst.syncOe, 1'b0);
        chk("bankOe", sbm_bus_if_inst.bankSelectOeM, 1'b0);
        rd[0] = sbm_bus_if_inst.phi1Clk;
        cyc(4);
        chk("phi1", sbm_bus_if_inst.phi1Clk, !rd[0]);
        reqValid = 1'b1;
        for (cnt = 0; cnt < 20 && reqReady !== 1'b1; cnt++) cyc(1);
        chk("refused", 16'(cnt), 16'd20);
        reqValid = 1'b0;
        floatReq = 1'b0;
        cyc(10);
        chk("addrBack", sbm_bus_if_inst.busAddrOe, 1'b1);
    endtask
    task automatic t_ovf;
        overflowPulse = 1'b1;
        cyc(2);
        overflowPulse = 1'b0;
        cyc(8);
        chk("ovfSet", overflowFlag, 1'b1);
        overflowClr = 1'b1;
        cyc(1);
        overflowClr = 1'b0;
        cyc(2);
        chk("ovfClr", overflowFlag, 1'b0);
    endtask
    // cases: external, programmed, level
    task automatic t_bank;
        logic [2:0] cs[5] = '{3'b010, 3'b011, 3'b000, 3'b100, 3'b101};
        logic       ln;
        for (int i = 0; i < 5; i++) begin
            {bankExternal, bankUseProg, bankProgLevel} = cs[i];
            bankDrive = cs[i][2];
            bankLevel = cs[i][0];
            ln = cs[i][1] | cs[i][2] ? cs[i][0] : 1'b1;
            cyc(8);
            chk("bankLine", sbm_bus_if_inst.bankSelectN, ln);
            chk("bankUpper", bankUpper, !ln);
            chk("seenBank0", seenBank0, ln);
            if (cs[i][2]) chk("bankOeM", sbm_bus_if_inst.bankSelectOeM, 1'b0);
        end
        {bankExternal, bankDrive} = 2'b00;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        {ref_clk, resetn, reqValid, reqWrite, reqFetch, overflowClr} = 6'h00;
        {bankExternal, bankUseProg, bankProgLevel, floatReq, holdReq} = 5'h00;
        {overflowPulse, bankDrive, bankLevel, dataDrive} = 4'h0;
        {reqAddr, reqWdata, dataOut, err_total, n_checks} = '0;
        dataOut = 8'h3c;
        cyc(12);
        resetn = 1'b1;
        cyc(2);
        t_rw;
        t_hold;
        t_float;
        t_ovf;
        t_bank;
        stop_test;
    end
    // whole run is well under a thousand cycles
    initial begin
        #40000;
        err_total++;
        stop_test;
    end
endmodule
`default_nettype wire
